// File: core/tra_controller.sv
`timescale 1ns/1ps
module tra_controller (
	input wire logic mclk_in,
	input wire logic rst_in,
	tra_link_if.controller link,
	input wire logic req_valid_in,
	input wire logic [tra_pkg::CH_W-1:0] req_ch_in,
	input wire logic req_write_in,
	input wire logic [5:0] req_index_in,
	input wire logic [15:0] req_data_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [15:0] rd_data_out,
	output logic [tra_pkg::NUM_CH-1:0][7:0] pd_status_out,
	output logic [tra_pkg::NUM_CH-1:0][15:0] pd_word_out
);
	import tra_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} tra_cst_t;
	tra_cst_t st_ff, nxt_st;
	logic [CH_W-1:0] ch_ff, nxt_ch;
	logic [7:0] ctl_ff, nxt_ctl, exp_ff, nxt_exp;
	logic [15:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic done_ff, nxt_done;
	logic [NUM_CH-1:0][7:0] pds_ff, nxt_pds;
	logic [NUM_CH-1:0][15:0] pdw_ff, nxt_pdw;

	always_comb begin
		nxt_st = st_ff;
		nxt_ch = ch_ff;
		nxt_ctl = ctl_ff;
		nxt_exp = exp_ff;
		nxt_wd = wd_ff;
		nxt_rd = rd_ff;
		nxt_done = 1'b0;
		nxt_pds = pds_ff;
		nxt_pdw = pdw_ff;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (!link.sts_byte[ch][CTL_REG_BIT]) begin
				nxt_pds[ch] = link.sts_byte[ch];
				nxt_pdw[ch] = link.in_word[ch];
			end
		end
		case (st_ff)
			ST_IDLE: begin
				if (req_valid_in) begin
					nxt_ch = req_ch_in;
					nxt_ctl = tra_ctl_byte(req_write_in, req_index_in);
					nxt_exp = tra_ctl_byte(1'b0, req_index_in);
					if (!req_write_in)
						nxt_exp = nxt_ctl;
					nxt_wd = req_data_in;
					nxt_st = ST_SEND;
				end
			end
			ST_SEND: nxt_st = ST_WAIT;
			ST_WAIT: begin
				// finished only on matching acknowledge
				if (link.sts_byte[ch_ff] == exp_ff) begin
					nxt_rd = link.in_word[ch_ff];
					nxt_done = 1'b1;
					nxt_ctl = 8'h00;
					nxt_st = ST_IDLE;
				end
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st_ff <= ST_IDLE;
			ch_ff <= '0;
			ctl_ff <= 8'h00;
			exp_ff <= 8'h00;
			wd_ff <= 16'h0000;
			rd_ff <= 16'h0000;
			done_ff <= 1'b0;
			pds_ff <= '0;
			pdw_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			ch_ff <= nxt_ch;
			ctl_ff <= nxt_ctl;
			exp_ff <= nxt_exp;
			wd_ff <= nxt_wd;
			rd_ff <= nxt_rd;
			done_ff <= nxt_done;
			pds_ff <= nxt_pds;
			pdw_ff <= nxt_pdw;
		end
	end

	always_comb begin
		for (int ch = 0; ch < NUM_CH; ch++) begin
			link.ctl_byte[ch] = 8'h00;
			link.out_word[ch] = 16'h0000;
		end
		if (st_ff != ST_IDLE) begin
			link.ctl_byte[ch_ff] = ctl_ff;
			link.out_word[ch_ff] = wd_ff;
		end
	end
	assign link.cycle_strobe = 1'b1;
	assign req_ready_out = (st_ff == ST_IDLE);
	assign done_out = done_ff;
	assign rd_data_out = rd_ff;
	assign pd_status_out = pds_ff;
	assign pd_word_out = pdw_ff;
endmodule // tra_controller

// File: core/tra_terminal.sv
`timescale 1ns/1ps
// Functional notes
// - status: b7 zero, b6 error, b1 over, b0 under
// - control byte ignored in process-data mode
// - control bit 7 selects register access
// - control bit 6: zero read, one write
// - read returns value, register unchanged
// - controller waits for write acknowledge
// - six low bits address 64 registers
// - read acknowledge echoes control byte
// - write acknowledge clears bit 6
// - status byte then 16-bit word, high first
// - coupler variant inserts pad byte
// - register 8 returns type identifier
// - register 9 returns firmware ASCII version
// - code word 0x1235 written to register 31
// - offset and gain per channel
// - one shared cold-junction gain
// - offset calibration uses feature 0xF100
// - raw output 4 uV per digit
// - cold-junction calibration via shared gain
// - writes locked unless code word present
// - writes take effect after power cycle; the register 31 code word unlocks at once
module tra_terminal (
	input wire logic mclk_in,
	input wire logic rst_in,
	tra_link_if.terminal link,
	input wire logic [tra_pkg::NUM_CH-1:0][15:0] sample_in,
	input wire logic [tra_pkg::NUM_CH-1:0] error_in,
	input wire logic [tra_pkg::NUM_CH-1:0] over_in,
	input wire logic [tra_pkg::NUM_CH-1:0] under_in,
	input wire logic power_cycle_in,
	output logic [tra_pkg::NUM_CH-1:0][15:0] tc_offset_out,
	output logic [tra_pkg::NUM_CH-1:0][15:0] tc_gain_out,
	output logic [15:0] cj_gain_out,
	output logic [15:0] feature_out,
	output logic unlocked_out
);
	import tra_pkg::*;

	// stored (written) and active (applied) copies
	logic [NUM_CH-1:0][15:0] off_ff, nxt_off, gain_ff, nxt_gain;
	logic [NUM_CH-1:0][15:0] off_act_ff, nxt_off_act;
	logic [NUM_CH-1:0][15:0] gain_act_ff, nxt_gain_act;
	logic [15:0] cj_ff, nxt_cj, cj_act_ff, nxt_cj_act;
	logic [15:0] feat_ff, nxt_feat, feat_act_ff, nxt_feat_act;
	logic [15:0] unlock_ff, nxt_unlock;
	logic [NUM_CH-1:0][7:0] sts_ff, nxt_sts;
	logic [NUM_CH-1:0][15:0] inw_ff, nxt_inw;
	logic [1:0] pc_sync_ff, nxt_pc_sync;
	logic pc_prev_ff, nxt_pc_prev;
	logic [NUM_CH-1:0][15:0] smp_s1_ff, smp_s2_ff;
	logic [NUM_CH-1:0] err_s1_ff, err_s2_ff, ovr_s1_ff, ovr_s2_ff;
	logic [NUM_CH-1:0] und_s1_ff, und_s2_ff;

	// register read mux; unmapped indices return zero
	function automatic logic [15:0] rd_reg(input logic [5:0] idx,
			input logic [15:0] off, input logic [15:0] gain,
			input logic [15:0] cj, input logic [15:0] feat,
			input logic [15:0] unl);
		case (idx)
			REG_TYPE_ID: rd_reg = TYPE_ID_VAL;
			REG_FW_VER: rd_reg = FW_VER_VAL;
			REG_TC_OFFSET: rd_reg = off;
			REG_TC_GAIN: rd_reg = gain;
			REG_CJ_GAIN: rd_reg = cj;
			REG_UNLOCK: rd_reg = unl;
			REG_FEATURE: rd_reg = feat;
			default: rd_reg = 16'h0000;
		endcase
	endfunction

	function automatic logic is_unlocked(input logic [15:0] code);
		is_unlocked = (code == UNLOCK_CODE);
	endfunction

	// process-data status: bit 7 and reserved bits stay zero
	function automatic logic [7:0] pd_status(input logic err,
			input logic ovr, input logic und);
		pd_status = 8'h00;
		pd_status[STS_ERR_BIT] = err;
		pd_status[STS_OVR_BIT] = ovr;
		pd_status[STS_UND_BIT] = und;
	endfunction

	// write acknowledge: control byte with the direction bit cleared
	function automatic logic [7:0] wr_ack(input logic [7:0] ctl);
		wr_ack = ctl;
		wr_ack[CTL_WR_BIT] = 1'b0;
	endfunction

	always_comb begin
		logic power_edge;
		logic unl_now;
		logic [7:0] c;
		logic [15:0] w;
		power_edge = 1'b0;
		unl_now = 1'b0;
		c = 8'h00;
		w = 16'h0000;
		nxt_off = off_ff;
		nxt_gain = gain_ff;
		nxt_cj = cj_ff;
		nxt_feat = feat_ff;
		nxt_unlock = unlock_ff;
		nxt_sts = sts_ff;
		nxt_inw = inw_ff;
		nxt_pc_sync = {pc_sync_ff[0], power_cycle_in};
		nxt_pc_prev = pc_sync_ff[1];
		// rising edge of the synced power-cycle level
		power_edge = pc_sync_ff[1] & ~pc_prev_ff;
		nxt_off_act = off_act_ff;
		nxt_gain_act = gain_act_ff;
		nxt_cj_act = cj_act_ff;
		nxt_feat_act = feat_act_ff;
		if (power_edge) begin
			nxt_off_act = off_ff;
			nxt_gain_act = gain_ff;
			nxt_cj_act = cj_ff;
			nxt_feat_act = feat_ff;
		end
		// compared before this strobe's own write lands
		unl_now = is_unlocked(unlock_ff);
		// each strobe is one process-image exchange
		if (link.cycle_strobe) begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				c = link.ctl_byte[ch];
				w = link.out_word[ch];
				if (c[CTL_REG_BIT]) begin
					if (c[CTL_WR_BIT]) begin
						if (c[5:0] == REG_UNLOCK) begin
							nxt_unlock = w;
						end else if (unl_now) begin
							case (c[5:0])
								REG_TC_OFFSET: nxt_off[ch] = w;
								REG_TC_GAIN: nxt_gain[ch] = w;
								REG_CJ_GAIN: nxt_cj = w;
								REG_FEATURE: nxt_feat = w;
								default: ;
							endcase
						end
						// a held write repeats harmlessly
						nxt_sts[ch] = wr_ack(c);
						nxt_inw[ch] = 16'h0000;
					end else begin
						nxt_sts[ch] = c;
						nxt_inw[ch] = rd_reg(c[5:0], off_ff[ch],
							gain_ff[ch], cj_ff, feat_ff, unlock_ff);
					end
				end else begin
					// control byte content ignored here
					nxt_sts[ch] = pd_status(err_s2_ff[ch], ovr_s2_ff[ch],
						und_s2_ff[ch]);
					nxt_inw[ch] = smp_s2_ff[ch];
				end
			end
		end
	end

	// two-stage synchronisers for the front-end levels
	always_ff @(posedge mclk_in) begin
		smp_s1_ff <= sample_in;
		smp_s2_ff <= smp_s1_ff;
		err_s1_ff <= error_in;
		err_s2_ff <= err_s1_ff;
		ovr_s1_ff <= over_in;
		ovr_s2_ff <= ovr_s1_ff;
		und_s1_ff <= under_in;
		und_s2_ff <= und_s1_ff;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			off_ff <= {NUM_CH{TC_OFFSET_RST}};
			gain_ff <= {NUM_CH{GAIN_RST}};
			off_act_ff <= {NUM_CH{TC_OFFSET_RST}};
			gain_act_ff <= {NUM_CH{GAIN_RST}};
			cj_ff <= GAIN_RST;
			cj_act_ff <= GAIN_RST;
			feat_ff <= FEATURE_RST;
			feat_act_ff <= FEATURE_RST;
			unlock_ff <= UNLOCK_RST;
			sts_ff <= '0;
			inw_ff <= '0;
			pc_sync_ff <= 2'h0;
			pc_prev_ff <= 1'b0;
		end else begin
			off_ff <= nxt_off;
			gain_ff <= nxt_gain;
			off_act_ff <= nxt_off_act;
			gain_act_ff <= nxt_gain_act;
			cj_ff <= nxt_cj;
			cj_act_ff <= nxt_cj_act;
			feat_ff <= nxt_feat;
			feat_act_ff <= nxt_feat_act;
			unlock_ff <= nxt_unlock;
			sts_ff <= nxt_sts;
			inw_ff <= nxt_inw;
			pc_sync_ff <= nxt_pc_sync;
			pc_prev_ff <= nxt_pc_prev;
		end
	end

	// link answers and active values come straight from flops
	assign link.sts_byte = sts_ff;
	assign link.in_word = inw_ff;
	assign tc_offset_out = off_act_ff;
	assign tc_gain_out = gain_act_ff;
	assign cj_gain_out = cj_act_ff;
	assign feature_out = feat_act_ff;
	assign unlocked_out = is_unlocked(unlock_ff);
endmodule // tra_terminal

// File: inc/tra_link_if.sv
`timescale 1ns/1ps
interface tra_link_if;
	import tra_pkg::*;
	// per channel: out = controller to terminal, in = terminal to controller
	logic [NUM_CH-1:0][7:0] ctl_byte;
	logic [NUM_CH-1:0][15:0] out_word;
	logic [NUM_CH-1:0][7:0] sts_byte;
	logic [NUM_CH-1:0][15:0] in_word;
	logic cycle_strobe;

	modport terminal (input ctl_byte, input out_word, input cycle_strobe,
		output sts_byte, output in_word);
	modport controller (output ctl_byte, output out_word,
		output cycle_strobe, input sts_byte, input in_word);
endinterface

// File: inc/tra_pkg.sv
package tra_pkg;
	// process image: control/status byte plus one 16-bit data word
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 6;
	localparam int NUM_REGS = 64;
	localparam int NUM_CH = 2;
	localparam int CH_W = 1;

	// control and status byte field positions
	localparam int CTL_REG_BIT = 7;
	localparam int CTL_WR_BIT = 6;
	localparam int STS_ERR_BIT = 6;
	localparam int STS_OVR_BIT = 1;
	localparam int STS_UND_BIT = 0;

	// register indices
	localparam logic [5:0] REG_TYPE_ID = 6'h08;
	localparam logic [5:0] REG_FW_VER = 6'h09;
	localparam logic [5:0] REG_TC_OFFSET = 6'h11;
	localparam logic [5:0] REG_TC_GAIN = 6'h12;
	localparam logic [5:0] REG_CJ_GAIN = 6'h15;
	localparam logic [5:0] REG_UNLOCK = 6'h1F;
	localparam logic [5:0] REG_FEATURE = 6'h20;

	localparam logic [15:0] UNLOCK_CODE = 16'h1235;
	// identity values: arbitrary
	localparam logic [15:0] TYPE_ID_VAL = 16'h00A5;
	localparam logic [15:0] FW_VER_VAL = 16'h3130;
	// reset values (plain defaults)
	localparam logic [15:0] TC_OFFSET_RST = 16'h0000;
	localparam logic [15:0] GAIN_RST = 16'h0100;
	localparam logic [15:0] FEATURE_RST = 16'h0000;
	localparam logic [15:0] UNLOCK_RST = 16'h0000;

	// 4 uV per digit in raw calibration view
	localparam int RAW_UV_PER_DIGIT = 4;
	localparam int GAIN_FRAC_BITS = 8;

	function automatic logic [7:0] tra_ctl_byte(input logic wr,
			input logic [5:0] idx);
		tra_ctl_byte = {1'b1, wr, idx};
	endfunction
endpackage

// File: testbench/terminal_register_access_tb_top.sv
`timescale 1ns/1ps
module terminal_register_access_tb_top;
	import tra_pkg::*;
	logic mclk_in, rst_in, req_valid, req_write, req_ready, done, unlocked;
	logic req_ch, pwr;
	logic [5:0] req_idx;
	logic [15:0] req_data, rd_data, feature;
	logic [NUM_CH-1:0][15:0] sample, pd_word;
	logic [NUM_CH-1:0][7:0] pd_sts;
	logic [NUM_CH-1:0] err, ovr, und;
	logic [NUM_CH-1:0][15:0] tc_off, tc_gain;
	logic [15:0] cj_gain;
	int fails = 0;
	int n_compared = 0;
	tra_link_if link ();
	tra_terminal tra_terminal_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.link(link), .sample_in(sample), .error_in(err), .over_in(ovr),
		.under_in(und), .power_cycle_in(pwr), .tc_offset_out(tc_off),
		.tc_gain_out(tc_gain), .cj_gain_out(cj_gain), .feature_out(feature),
		.unlocked_out(unlocked));
	tra_controller tra_controller_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.link(link), .req_valid_in(req_valid), .req_ch_in(req_ch),
		.req_write_in(req_write), .req_index_in(req_idx),
		.req_data_in(req_data), .req_ready_out(req_ready), .done_out(done),
		.rd_data_out(rd_data), .pd_status_out(pd_sts), .pd_word_out(pd_word));
	tra_monitor tra_monitor_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.ctl_byte_in(link.ctl_byte), .out_word_in(link.out_word),
		.sts_byte_in(link.sts_byte), .in_word_in(link.in_word),
		.cycle_strobe_in(link.cycle_strobe));
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one register transfer through the controller, waits for done
	task automatic acc(input logic ch, input logic wr, input logic [5:0] idx,
			input logic [15:0] d);
		int n;
		n = 0;
		@(negedge mclk_in);
		while (req_ready !== 1'h1 && n < 20) begin
			@(negedge mclk_in);
			n++;
		end
		req_valid = 1'h1;
		req_ch = ch;
		req_write = wr;
		req_idx = idx;
		req_data = d;
		@(negedge mclk_in);
		req_valid = 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 20) begin
			@(negedge mclk_in);
			n++;
		end
		if (n == 20) fails++;
	endtask
	task automatic rd_chk(input logic ch, input logic [5:0] idx,
			input logic [15:0] exp);
		acc(ch, 1'h0, idx, 16'h0000);
		chk16(rd_data, exp);
	endtask
	task automatic pwr_cycle();
		pwr = 1'h1;
		repeat (6) @(negedge mclk_in);
		pwr = 1'h0;
	endtask
	task automatic t_pd();
		sample = {16'h0BCD, 16'h1234};
		err = 2'h1;
		ovr = 2'h2;
		und = 2'h1;
		repeat (8) @(negedge mclk_in);
		chk8(pd_sts[0], 8'h41);
		chk8(pd_sts[1], 8'h02);
		chk16(pd_word[0], 16'h1234);
		chk16(pd_word[1], 16'h0BCD);
	endtask
	task automatic t_ids();
		rd_chk(1'h0, REG_TYPE_ID, TYPE_ID_VAL);
		rd_chk(1'h1, REG_FW_VER, FW_VER_VAL);
		rd_chk(1'h0, 6'h3F, 16'h0000);
	endtask
	task automatic t_lock();
		acc(1'h0, 1'h1, REG_FEATURE, 16'h0002);
		rd_chk(1'h0, REG_FEATURE, FEATURE_RST);
		acc(1'h0, 1'h1, REG_UNLOCK, 16'h1235);
		chk16({15'h0, unlocked}, 16'h0001);
		rd_chk(1'h0, REG_UNLOCK, 16'h1235);
		acc(1'h0, 1'h1, REG_FEATURE, 16'hF100);
		rd_chk(1'h1, REG_FEATURE, 16'hF100);
		chk16(feature, FEATURE_RST);
		pwr_cycle();
		chk16(feature, 16'hF100);
		acc(1'h0, 1'h1, REG_TC_OFFSET, 16'h0011);
		acc(1'h1, 1'h1, REG_TC_OFFSET, 16'h0022);
		rd_chk(1'h0, REG_TC_OFFSET, 16'h0011);
		rd_chk(1'h1, REG_TC_OFFSET, 16'h0022);
		acc(1'h0, 1'h1, REG_CJ_GAIN, 16'h0123);
		rd_chk(1'h1, REG_CJ_GAIN, 16'h0123);
		acc(1'h1, 1'h1, REG_FEATURE, 16'h1006);
		acc(1'h1, 1'h1, REG_TC_GAIN, 16'h0200);
		chk16(tc_off[0], TC_OFFSET_RST);
		pwr_cycle();
		chk16(tc_off[0], 16'h0011);
		chk16(tc_off[1], 16'h0022);
		chk16(tc_gain[0], GAIN_RST);
		chk16(tc_gain[1], 16'h0200);
		chk16(cj_gain, 16'h0123);
		chk16(feature, 16'h1006);
		acc(1'h0, 1'h1, REG_UNLOCK, 16'h0000);
		chk16({15'h0, unlocked}, 16'h0000);
		acc(1'h0, 1'h1, REG_TC_GAIN, 16'h0777);
		rd_chk(1'h0, REG_TC_GAIN, GAIN_RST);
	endtask
	task automatic t_rst();
		rst_in = 1'h1;
		repeat (3) @(negedge mclk_in);
		rst_in = 1'h0;
		chk16(feature, FEATURE_RST);
		chk16(cj_gain, GAIN_RST);
		chk8(pd_sts[0], 8'h00);
		rd_chk(1'h1, REG_TC_OFFSET, TC_OFFSET_RST);
	endtask
	task automatic tally_and_finish();
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		mclk_in = 1'h0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	initial begin
		rst_in = 1'h1;
		req_valid = 1'h0;
		req_ch = 1'h0;
		req_write = 1'h0;
		req_idx = 6'h00;
		req_data = 16'h0000;
		sample = '0;
		err = 2'h0;
		ovr = 2'h0;
		und = 2'h0;
		pwr = 1'h0;
		repeat (10) @(posedge mclk_in);
		@(negedge mclk_in);
		rst_in = 1'h0;
		t_pd();
		t_ids();
		t_lock();
		t_rst();
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge mclk_in);
		fails++;
		tally_and_finish();
	end
endmodule // terminal_register_access_tb_top

// File: testbench/tra_monitor.sv
`timescale 1ns/1ps
module tra_monitor (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [tra_pkg::NUM_CH-1:0][7:0] ctl_byte_in,
	input wire logic [tra_pkg::NUM_CH-1:0][15:0] out_word_in,
	input wire logic [tra_pkg::NUM_CH-1:0][7:0] sts_byte_in,
	input wire logic [tra_pkg::NUM_CH-1:0][15:0] in_word_in,
	input wire logic cycle_strobe_in
);
	import tra_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	property p_rd_ack;
		cycle_strobe_in && ctl_byte_in[0][7:6] == 2'h2
			|=> sts_byte_in[0] == $past(ctl_byte_in[0]);
	endproperty
	a_rd_ack: assert property (p_rd_ack)
		else $error("read acknowledge differs from control byte");
	property p_wr_ack;
		cycle_strobe_in && ctl_byte_in[0][7:6] == 2'h3
			|=> sts_byte_in[0] == {2'h2, $past(ctl_byte_in[0][5:0])};
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("write acknowledge wrong");
	property p_pd_top;
		cycle_strobe_in && !ctl_byte_in[0][7] |=> !sts_byte_in[0][7];
	endproperty
	a_pd_top: assert property (p_pd_top)
		else $error("status bit 7 set in process mode");
	property p_pd_rsv;
		cycle_strobe_in && !ctl_byte_in[1][7]
			|=> sts_byte_in[1][5:2] == 4'h0;
	endproperty
	a_pd_rsv: assert property (p_pd_rsv)
		else $error("reserved status bits not zero");
	property p_type;
		cycle_strobe_in && ctl_byte_in[0] == 8'h88
			|=> in_word_in[0] == TYPE_ID_VAL;
	endproperty
	a_type: assert property (p_type)
		else $error("type identifier wrong");
	property p_fw;
		cycle_strobe_in && ctl_byte_in[1] == 8'h89
			|=> in_word_in[1] == FW_VER_VAL;
	endproperty
	a_fw: assert property (p_fw)
		else $error("firmware version wrong");
	property p_ch1_ack;
		cycle_strobe_in && ctl_byte_in[1][7:6] == 2'h2
			|=> sts_byte_in[1] == $past(ctl_byte_in[1]);
	endproperty
	a_ch1_ack: assert property (p_ch1_ack)
		else $error("channel 1 read acknowledge wrong");
	property p_rd_hold;
		cycle_strobe_in && ctl_byte_in[0][7:6] == 2'h2
			&& $stable(ctl_byte_in[0])
			|=> $stable(in_word_in[0]);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("repeated read changed value");
endmodule // tra_monitor
